//--- bench/cprs_core_mem.sv
// core memory model standing behind the register set's memory buffer
// assumes one write pulse per stored word; reads are combinational sense outputs
`timescale 1ns/1ps
module cprs_core_mem (
   input  wire logic                        clock_in,
   input  wire logic [cprs_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [cprs_pkg::WORD_W-1:0] data_in,
   input  wire logic                        wr_in,
   output logic      [cprs_pkg::WORD_W-1:0] sense_out
);
   logic [cprs_pkg::WORD_W-1:0] mem_ff [0:cprs_pkg::ERAS_LOCATIONS-1];
   // erasable select uses the low ten address bits only
   always_ff @(posedge clock_in) begin
      if (wr_in) mem_ff[addr_in[cprs_pkg::ERAS_W-1:0]] <= data_in;
   end
   // unwritten cells stay unknown, so a stray load is never mistaken for data
   assign sense_out = mem_ff[addr_in[cprs_pkg::ERAS_W-1:0]];
endmodule : cprs_core_mem

//--- bench/cprs_reg_set_monitor.sv
// checker for the central register set, bound to every instance
// assumes strobes from the sequence generator last one clock_in cycle
`timescale 1ns/1ps
module cprs_reg_set_monitor
   import cprs_pkg::*;
(
   input wire logic clock_in, rst_b_in, counter_read_strobe_in, low_product_write_strobe_in,
   input wire logic low_product_clear_strobe_in, multiply_shift_write_strobe_in,
   input wire logic instr_buffer_read_inverted_in, address_write_pulse_in,
   input wire logic multiply_first_subinstruction_in, address_reg_clear_strobe_in,
   input wire logic new_instruction_request_in, interrupt_request_pending_in,
   input wire logic restart_request_in, ground_test_start_request_in,
   input wire logic monitor_interrupt_inhibit_in, sense_load_strobe_in, buffer_clear_strobe_in,
   input wire logic interrupt_active_out, special_transfer_control_out,
   input wire logic [WORD_W-1:0] write_line_bus_bit_in, sense_amplifier_output_in,
   input wire logic [WORD_W-1:0] write_line_drive_out, counter_out, low_product_register_out,
   input wire logic [WORD_W-1:0] instr_buffer_out, buffer_to_memory_line_out,
   input wire logic [SLOT_W-1:0] memory_cycle_time_in,
   input wire logic [ADDR_W-1:0] address_reg_output_bit_out, address_reg_output_bit_n_out,
   input wire logic [ORDER_W-1:0] order_code_register_out, order_code_register_n_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   // time-12 request and either start request
   wire t12 = new_instruction_request_in && memory_cycle_time_in == SLOT_NEW_INSTR;
   wire st  = restart_request_in || ground_test_start_request_in;
   wire ald = address_write_pulse_in && memory_cycle_time_in == SLOT_ADDR_LOAD
              && !multiply_first_subinstruction_in;
   property p_cmpl; address_reg_output_bit_n_out == ~address_reg_output_bit_out
      && order_code_register_n_out == ~order_code_register_out; endproperty
   a_cmpl: assert property (p_cmpl) else $error("complement outputs disagree");
   property p_aload; ald && address_reg_clear_strobe_in
      |=> address_reg_output_bit_out == $past(write_line_bus_bit_in[ADDR_W-1:0]); endproperty
   a_aload: assert property (p_aload) else $error("address load wrong");
   property p_ahold; !ald && !address_reg_clear_strobe_in
      |=> $stable(address_reg_output_bit_out); endproperty
   a_ahold: assert property (p_ahold) else $error("address changed ungated");
   property p_norm; t12 && !st && (!interrupt_request_pending_in || interrupt_active_out
      || monitor_interrupt_inhibit_in)
      |=> order_code_register_out == $past(instr_buffer_out[WORD_W-1:ORDER_LO_POS]); endproperty
   a_norm: assert property (p_norm) else $error("order code not from buffer");
   property p_int; t12 && interrupt_request_pending_in && !st && !interrupt_active_out
      && !monitor_interrupt_inhibit_in
      |=> order_code_register_out == ORDER_INTERRUPT && interrupt_active_out; endproperty
   a_int: assert property (p_int) else $error("interrupt order code wrong");
   property p_start; t12 && st |=> order_code_register_out == ORDER_START
      && special_transfer_control_out == !$past(restart_request_in); endproperty
   a_start: assert property (p_start) else $error("start order code wrong");
   property p_zrd; counter_read_strobe_in
      |=> (write_line_drive_out & $past(counter_out)) == $past(counter_out); endproperty
   a_zrd: assert property (p_zrd) else $error("counter readout missing");
   property p_inv; instr_buffer_read_inverted_in
      |=> (write_line_drive_out & ~$past(instr_buffer_out)) == ~$past(instr_buffer_out);
   endproperty
   a_inv: assert property (p_inv) else $error("complement readout missing");
   property p_lowp; low_product_write_strobe_in && low_product_clear_strobe_in
      && !multiply_shift_write_strobe_in |=> low_product_register_out ==
      {{3{$past(write_line_bus_bit_in[0])}}, $past(write_line_bus_bit_in[13:1])}; endproperty
   a_lowp: assert property (p_lowp) else $error("low product mapping wrong");
   property p_sense; sense_load_strobe_in && buffer_clear_strobe_in
      && memory_cycle_time_in <= SLOT_SENSE_LAST
      |=> buffer_to_memory_line_out == $past(sense_amplifier_output_in); endproperty
   a_sense: assert property (p_sense) else $error("sense word not loaded");
   c_int: cover property (t12 && interrupt_request_pending_in && !interrupt_active_out);
   c_start: cover property (t12 && ground_test_start_request_in && !restart_request_in);
   c_sense: cover property (sense_load_strobe_in && buffer_clear_strobe_in);
endmodule : cprs_reg_set_monitor
bind cprs_reg_set cprs_reg_set_monitor mon (.*);

//--- bench/testbench.sv
// self-checking bench for the central register set with a core memory model
// assumes the design releases reset through its own two-flop synchroniser
`timescale 1ns/1ps
module testbench;
   import cprs_pkg::*;
   typedef struct {logic [24:0] w, r; logic [15:0] d, e, x; int k;} cprs_row_t;
   logic clock_in, rst_b_in;
   logic [24:0] s;
   logic [15:0] wl, sense, write_line_drive_out, counter_out, low_product_register_out;
   logic [15:0] instr_buffer_out, buffer_to_memory_line_out;
   logic [11:0] address_reg_output_bit_out, address_reg_output_bit_n_out;
   logic [3:0]  slot, order_code_register_out, order_code_register_n_out;
   logic        interrupt_active_out, interrupt_inhibit_out, special_transfer_control_out;
   int          fails = 0, checks_done = 0;
   // write mask, read mask, data, register value, readout value, register pick
   cprs_row_t rows [6] = '{'{25'h3, 25'h4, 16'hA5C3, 16'hA5C3, 16'hA5C3, 0},
      '{25'h50, 25'h20, 16'h0001, 16'h2000, 16'h2000, 1},
      '{25'h18, 25'h20, 16'h0003, 16'hE001, 16'hE001, 1},
      '{25'h18, 25'h20, 16'h4AAA, 16'h0555, 16'h0555, 1},
      '{25'h180, 25'h200, 16'h3C5A, 16'h3C5A, 16'h3C5A, 2},
      '{25'h180, 25'h400, 16'h3C5A, 16'h3C5A, 16'hC3A5, 2}};
   cprs_reg_set dut (.write_line_bus_bit_in(wl), .memory_cycle_time_in(slot),
      .counter_write_strobe_in(s[0]), .counter_clear_strobe_in(s[1]),
      .counter_read_strobe_in(s[2]), .low_product_write_strobe_in(s[3]),
      .low_product_clear_strobe_in(s[4]), .low_product_read_strobe_in(s[5]),
      .multiply_shift_write_strobe_in(s[6]), .instr_buffer_write_strobe_in(s[7]),
      .instr_buffer_clear_strobe_in(s[8]), .instr_buffer_read_strobe_in(s[9]),
      .instr_buffer_read_inverted_in(s[10]), .address_write_pulse_in(s[11]),
      .multiply_first_subinstruction_in(s[12]), .address_reg_clear_strobe_in(s[13]),
      .new_instruction_request_in(s[14]), .interrupt_request_pending_in(s[15]),
      .interrupt_return_in(s[16]), .restart_request_in(s[17]),
      .ground_test_start_request_in(s[18]), .monitor_interrupt_inhibit_in(s[19]),
      .sense_load_strobe_in(s[20]), .buffer_write_strobe_in(s[21]),
      .buffer_clear_strobe_in(s[22]), .parity_bit_write_in(s[23]),
      .sense_amplifier_output_in(sense), .*);
   cprs_core_mem mem (.clock_in(clock_in), .addr_in(address_reg_output_bit_out),
      .data_in(buffer_to_memory_line_out), .wr_in(s[24]), .sense_out(sense));
   initial begin
      clock_in = 1'b0;
      forever #4 clock_in = ~clock_in;
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // one strobe cycle; read 1 ns after the edge that takes it, where outputs settle
   task automatic go(input logic [24:0] m, input logic [15:0] w, input logic [3:0] t);
      @(posedge clock_in);
      s <= m;
      wl <= w;
      slot <= t;
      @(posedge clock_in);
      s <= '0;
      #1;
   endtask : go
   task automatic results;
      if (fails == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : results
   initial begin
      s = '0;
      wl = '0;
      slot = '0;
      rst_b_in = 1'b0;
      repeat (4) @(posedge clock_in);
      rst_b_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      #1;
      chk({address_reg_output_bit_n_out, order_code_register_n_out}, 16'hFFFF);
      foreach (rows[i]) begin
         go(rows[i].w, rows[i].d, 4'h0);
         chk(rows[i].k == 0 ? counter_out : rows[i].k == 1 ? low_product_register_out
             : instr_buffer_out, rows[i].e);
         go(rows[i].r, 16'h0000, 4'h0);
         chk(write_line_drive_out, rows[i].x);
         @(posedge clock_in);
         #1;
         chk(write_line_drive_out, 16'h0000);
      end
      go(25'h1, 16'h000C, 4'h0);
      chk(counter_out, 16'hA5CF);
      go(25'h2800, 16'hF155, 4'h1);
      chk(address_reg_output_bit_out, 16'h0155);
      go(25'h0800, 16'h0AAA, 4'h2);
      go(25'h1800, 16'h0AAA, 4'h1);
      chk(address_reg_output_bit_n_out, 16'h0EAA);
      go(25'h600000, 16'hFFFF, 4'h0);
      chk(buffer_to_memory_line_out, 16'hBFFF);
      go(25'h600000, 16'h0003, 4'h0);
      go(25'h800000, 16'h0000, 4'h0);
      chk(buffer_to_memory_line_out, 16'h4003);
      go(25'h1000000, 16'h0000, 4'h0);
      go(25'h600000, 16'h0000, 4'h0);
      go(25'h100000, 16'h0000, 4'h7);
      chk(buffer_to_memory_line_out, 16'h0000);
      go(25'h500000, 16'h0000, 4'h6);
      chk(buffer_to_memory_line_out, 16'h4003);
      go(25'h2800, 16'h0011, 4'h1);
      go(25'h600000, 16'h8000, 4'h0);
      chk(buffer_to_memory_line_out, 16'hA000);
      go(25'h180, 16'hA000, 4'h0);
      go(25'h4000, 16'h0000, 4'hC);
      chk({write_line_drive_out[15:4], order_code_register_out}, 16'hA00A);
      go(25'hC000, 16'h0000, 4'hC);
      chk({write_line_drive_out[15:4], order_code_register_out}, 16'h0003);
      chk({interrupt_inhibit_out, interrupt_active_out}, 16'h0003);
      go(25'h4000, 16'h0000, 4'hB);
      chk(order_code_register_out, 16'h0003);
      go(25'hC000, 16'h0000, 4'hC);
      chk(order_code_register_out, 16'h000A);
      go(25'h2C000, 16'h0000, 4'hC);
      chk({special_transfer_control_out, interrupt_active_out, interrupt_inhibit_out,
           order_code_register_out}, 16'h0000);
      go(25'h64000, 16'h0000, 4'hC);
      chk({special_transfer_control_out, order_code_register_out}, 16'h0000);
      go(25'h44000, 16'h0000, 4'hC);
      chk({special_transfer_control_out, order_code_register_out}, 16'h0010);
      results();
   end
endmodule : testbench

//--- verilog/cprs_pkg.sv
// package of constants for the central register set
// assumes write-line bit n sits at vector index n-1
package cprs_pkg;

   // --------------------
   // widths
   // --------------------
   localparam int WORD_W   = 16;  // write lines and full registers
   localparam int ADDR_W   = 12;  // memory address register
   localparam int ERAS_W   = 10;  // erasable select part of the address
   localparam int ORDER_W  = 4;   // order-code register
   localparam int SLOT_W   = 4;   // memory-cycle time slot number
   localparam int ERAS_LOCATIONS = 1024;

   // --------------------
   // field positions (index = bit number - 1)
   // --------------------
   localparam int PARITY_POS   = 14;  // buffer bit 15
   localparam int SIGN_POS     = 15;  // bit 16
   localparam int LOWP_MULT_POS = 13; // low-product bit 14
   localparam int ORDER_LO_POS = 12;  // bits 13..14 of a word
   localparam int ORDER_HI_POS = 14;  // bits 15..16 of a word

   // --------------------
   // memory-cycle timing slots
   // --------------------
   localparam logic [SLOT_W-1:0] SLOT_ADDR_LOAD  = 4'h1;  // action 1
   localparam logic [SLOT_W-1:0] SLOT_SENSE_LAST = 4'h6;  // word valid by action 6
   localparam logic [SLOT_W-1:0] SLOT_NEW_INSTR  = 4'hC;  // time 12

   // --------------------
   // shift and cycle addresses, order codes, reset values
   // --------------------
   localparam logic [ADDR_W-1:0]  ADDR_CYCLE_RIGHT = 12'h010;  // octal 20
   localparam logic [ADDR_W-1:0]  ADDR_SHIFT_RIGHT = 12'h011;  // octal 21
   localparam logic [ADDR_W-1:0]  ADDR_CYCLE_LEFT  = 12'h012;  // octal 22
   localparam logic [ADDR_W-1:0]  ADDR_SHIFT_LEFT  = 12'h013;  // octal 23
   localparam logic [ORDER_W-1:0] ORDER_INTERRUPT  = 4'h3;     // 0011
   localparam logic [ORDER_W-1:0] ORDER_START      = 4'h0;     // 0000
   localparam logic [WORD_W-1:0]  WORD_RESET       = 16'h0000;
   localparam logic [ADDR_W-1:0]  ADDR_RESET       = 12'h000;
   localparam logic [ORDER_W-1:0] ORDER_RESET      = 4'h0;

   // buffer write modes chosen from the address register
   typedef enum logic [2:0] {
      CPRS_WR_NORMAL,
      CPRS_WR_CYCLE_RIGHT,
      CPRS_WR_SHIFT_RIGHT,
      CPRS_WR_CYCLE_LEFT,
      CPRS_WR_SHIFT_LEFT
   } cprs_wr_mode_t;

endpackage : cprs_pkg

//--- verilog/cprs_reg_set.sv
// central processor register set: counter, low product, instruction
// buffer, address and order-code registers, memory buffer
// assumes all strobes come from the sequence generator on clock_in,
// one cycle long, already decoded; no synchroniser is needed on them
//
// Contract
// - address and order-code registers: 16 bits, no read, both rails out
// - address is 12 bits; 10 pick erasable, all 12 pick fixed
// - address strobe loads write lines 1..12
// - address load at action 1, except on first multiply step
// - order code holds bits 13..16; 13..14 sequence path, 15..16 direct
// - request at time 11 arms; order code cleared at time 12
// - time 12 reads instruction buffer; upper, lower bits on separate strobes
// - interrupt at time 12 drops readout and upper strobe; code 0011
// - no interrupt during interrupt program; inhibit rests zero otherwise (here the monitor inhibit also sets it)
// - restart kills both order strobes, forces 0000, masks ground start
// - ground start kills order strobes, forces 0000 for special transfer
// - memory buffer carries every memory word, shifts or cycles when addressed
// - sense outputs load buffer under cycle timing, valid by action 6
// - buffer bit 15 is parity only, generated for erasable writes
// - buffer drives 16 memory-input lines
// - normal load from write lines skips bit 15; other sets shift only
// - low product bit n takes line n+1 up to 13, line 1 above; 14 multiply
// - instruction buffer: write, clear, true read, complement read
// - counter: common write, clear and read strobes
// - addresses octal 20..23 cycle/shift buffer right/left around bit 15
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.

`timescale 1ns/1ps

module cprs_reg_set
   import cprs_pkg::*;
(
   input  wire logic                          clock_in,
   input  wire logic                          rst_b_in,
   // write-line bus and memory-cycle timing
   input  wire logic [cprs_pkg::WORD_W-1:0]   write_line_bus_bit_in,
   input  wire logic [cprs_pkg::SLOT_W-1:0]   memory_cycle_time_in,
   // program counter
   input  wire logic                          counter_write_strobe_in,
   input  wire logic                          counter_clear_strobe_in,
   input  wire logic                          counter_read_strobe_in,
   // low product
   input  wire logic                          low_product_write_strobe_in,
   input  wire logic                          low_product_clear_strobe_in,
   input  wire logic                          low_product_read_strobe_in,
   input  wire logic                          multiply_shift_write_strobe_in,
   // instruction buffer
   input  wire logic                          instr_buffer_write_strobe_in,
   input  wire logic                          instr_buffer_clear_strobe_in,
   input  wire logic                          instr_buffer_read_strobe_in,
   input  wire logic                          instr_buffer_read_inverted_in,
   // address register and order code
   input  wire logic                          address_write_pulse_in,
   input  wire logic                          multiply_first_subinstruction_in,
   input  wire logic                          address_reg_clear_strobe_in,
   input  wire logic                          new_instruction_request_in,
   input  wire logic                          interrupt_request_pending_in,
   input  wire logic                          interrupt_return_in,
   input  wire logic                          restart_request_in,
   input  wire logic                          ground_test_start_request_in,
   input  wire logic                          monitor_interrupt_inhibit_in,
   // memory buffer
   input  wire logic [cprs_pkg::WORD_W-1:0]   sense_amplifier_output_in,
   input  wire logic                          sense_load_strobe_in,
   input  wire logic                          buffer_write_strobe_in,
   input  wire logic                          buffer_clear_strobe_in,
   input  wire logic                          parity_bit_write_in,
   // outputs
   output logic [cprs_pkg::WORD_W-1:0]        write_line_drive_out,
   output logic [cprs_pkg::WORD_W-1:0]        counter_out,
   output logic [cprs_pkg::WORD_W-1:0]        low_product_register_out,
   output logic [cprs_pkg::WORD_W-1:0]        instr_buffer_out,
   output logic [cprs_pkg::ADDR_W-1:0]        address_reg_output_bit_out,
   output logic [cprs_pkg::ADDR_W-1:0]        address_reg_output_bit_n_out,
   output logic [cprs_pkg::ORDER_W-1:0]       order_code_register_out,
   output logic [cprs_pkg::ORDER_W-1:0]       order_code_register_n_out,
   output logic [cprs_pkg::WORD_W-1:0]        buffer_to_memory_line_out,
   output logic                               interrupt_active_out,
   output logic                               interrupt_inhibit_out,
   output logic                               special_transfer_control_out
);
   import cprs_pkg::*;

   // --------------------
   // functions
   // --------------------

   // clear first, then wired-or the write in, as the gates do
   function automatic logic [WORD_W-1:0] clr_wr(input logic [WORD_W-1:0] cur,
                                                input logic              clr,
                                                input logic              wr,
                                                input logic [WORD_W-1:0] data);
      logic [WORD_W-1:0] v;
      v = clr ? WORD_RESET : cur;
      if (wr) begin
         v = v | data;
      end
      return v;
   endfunction : clr_wr

   // pick the 15 data bits around the parity position (bit 16 on top)
   function automatic logic [WORD_W-2:0] strip_parity(input logic [WORD_W-1:0] w);
      return {w[SIGN_POS], w[PARITY_POS-1:0]};
   endfunction : strip_parity

   // put 15 data bits back around a given parity bit
   function automatic logic [WORD_W-1:0] add_parity(input logic [WORD_W-2:0] d,
                                                    input logic              p);
      return {d[WORD_W-2], p, d[PARITY_POS-1:0]};
   endfunction : add_parity

   // --------------------
   // reset release
   // --------------------
   logic rst_meta_ff;
   logic rst_sync_ff;

   // async assert, two-stage release so no register leaves reset mid-edge
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   // --------------------
   // gated strobes
   // --------------------
   logic          at_time12;
   logic          newi_t12;
   logic          restart_eff;
   logic          gts_eff;
   logic          rupt_take;
   logic          lower_write;
   logic          upper_write;
   logic          order_readout;
   logic          addr_write;
   logic          sense_load;
   cprs_wr_mode_t wr_mode;

   logic [WORD_W-1:0]  counter_ff,  nxt_counter;
   logic [WORD_W-1:0]  lowp_ff,     nxt_lowp;
   logic [WORD_W-1:0]  ib_ff,       nxt_ib;
   logic [ADDR_W-1:0]  addr_ff,     nxt_addr;
   logic [ADDR_W-1:0]  addr_n_ff;
   logic [ORDER_W-1:0] order_ff,    nxt_order;
   logic [ORDER_W-1:0] order_n_ff;
   logic [WORD_W-1:0]  buf_ff,      nxt_buf;
   logic [WORD_W-1:0]  rdbus_ff,    nxt_rdbus;
   logic               rupt_act_ff;
   logic               inhibit_ff;
   logic               stc_ff;

   // the request raised at time 11 is honoured on the time-12 slot
   assign at_time12 = (memory_cycle_time_in == SLOT_NEW_INSTR);
   assign newi_t12  = new_instruction_request_in & at_time12;
   // restart masks the ground-test start entirely
   assign restart_eff = restart_request_in;
   assign gts_eff     = ground_test_start_request_in & ~restart_request_in;
   // block a new interrupt while one runs or while the monitor inhibits
   assign rupt_take   = newi_t12 & interrupt_request_pending_in & ~rupt_act_ff
                        & ~monitor_interrupt_inhibit_in & ~restart_eff & ~gts_eff;
   // both order strobes die on either start request
   assign lower_write   = newi_t12 & ~restart_eff & ~gts_eff;
   assign upper_write   = lower_write & ~rupt_take;
   assign order_readout = upper_write;
   // address load at action 1 except on the first multiply step
   assign addr_write = address_write_pulse_in & ~multiply_first_subinstruction_in
                       & (memory_cycle_time_in == SLOT_ADDR_LOAD);
   // sense data may only land up to action 6
   assign sense_load = sense_load_strobe_in
                       & (memory_cycle_time_in <= SLOT_SENSE_LAST);

   // --------------------
   // buffer write mode from the address register
   // --------------------
   // decode on the latched address, not the write lines
   always_comb begin
      unique case (addr_ff)
         ADDR_CYCLE_RIGHT: wr_mode = CPRS_WR_CYCLE_RIGHT;
         ADDR_SHIFT_RIGHT: wr_mode = CPRS_WR_SHIFT_RIGHT;
         ADDR_CYCLE_LEFT:  wr_mode = CPRS_WR_CYCLE_LEFT;
         ADDR_SHIFT_LEFT:  wr_mode = CPRS_WR_SHIFT_LEFT;
         default:          wr_mode = CPRS_WR_NORMAL;
      endcase
   end

   // --------------------
   // next values
   // --------------------
   // counter: plain common strobes
   always_comb begin
      nxt_counter = clr_wr(counter_ff, counter_clear_strobe_in,
                           counter_write_strobe_in, write_line_bus_bit_in);
   end

   // low product: one-place right shift from the write lines, line 1 fill
   always_comb begin
      logic [WORD_W-1:0] lpw;
      logic [WORD_W-1:0] mpw;
      lpw = {{3{write_line_bus_bit_in[0]}},
             write_line_bus_bit_in[LOWP_MULT_POS:1]};
      mpw = WORD_RESET;
      mpw[LOWP_MULT_POS] = write_line_bus_bit_in[0];
      nxt_lowp = clr_wr(lowp_ff, low_product_clear_strobe_in,
                        low_product_write_strobe_in, lpw);
      if (multiply_shift_write_strobe_in) begin
         nxt_lowp = nxt_lowp | mpw;
      end
   end

   // instruction buffer
   always_comb begin
      nxt_ib = clr_wr(ib_ff, instr_buffer_clear_strobe_in,
                      instr_buffer_write_strobe_in, write_line_bus_bit_in);
   end

   // address register, write lines 1..12 only
   always_comb begin
      nxt_addr = address_reg_clear_strobe_in ? ADDR_RESET : addr_ff;
      if (addr_write) begin
         nxt_addr = nxt_addr | write_line_bus_bit_in[ADDR_W-1:0];
      end
   end

   // order code: cleared at time 12, then two separate write strobes;
   // the buffer readout reaches the register directly in the same cycle
   always_comb begin
      nxt_order = order_ff;
      if (newi_t12) begin
         nxt_order = ORDER_START;
         if (upper_write) begin
            nxt_order[3:2] = ib_ff[ORDER_HI_POS +: 2];
         end
         if (rupt_take) begin
            nxt_order = nxt_order | ORDER_INTERRUPT;
         end else if (lower_write) begin
            nxt_order[1:0] = ib_ff[ORDER_LO_POS +: 2];
         end
      end
   end

   // memory buffer: sense load, write-line load or shift, parity insert
   always_comb begin
      logic [WORD_W-2:0] d;
      logic [WORD_W-2:0] s;
      d = strip_parity(write_line_bus_bit_in);
      s = d;
      nxt_buf = buffer_clear_strobe_in ? WORD_RESET : buf_ff;
      unique case (wr_mode)
         CPRS_WR_CYCLE_RIGHT: s = {d[0], d[WORD_W-2:1]};
         CPRS_WR_SHIFT_RIGHT: s = {d[WORD_W-2], d[WORD_W-2:1]};
         CPRS_WR_CYCLE_LEFT:  s = {d[WORD_W-3:0], d[WORD_W-2]};
         CPRS_WR_SHIFT_LEFT:  s = {d[WORD_W-3:0], 1'b0};
         CPRS_WR_NORMAL:      s = d;
      endcase
      if (buffer_write_strobe_in) begin
         // parity position is never written from the lines
         nxt_buf = nxt_buf | add_parity(s, 1'b0);
      end
      if (sense_load) begin
         nxt_buf = nxt_buf | sense_amplifier_output_in;
      end
      if (parity_bit_write_in) begin
         // odd parity over the fifteen data bits
         nxt_buf[PARITY_POS] = ~(^strip_parity(nxt_buf));
      end
   end

   // readout onto the write lines, registered: valid the cycle after
   always_comb begin
      nxt_rdbus = WORD_RESET;
      if (counter_read_strobe_in) begin
         nxt_rdbus = nxt_rdbus | counter_ff;
      end
      if (low_product_read_strobe_in) begin
         nxt_rdbus = nxt_rdbus | lowp_ff;
      end
      if (instr_buffer_read_strobe_in | order_readout) begin
         nxt_rdbus = nxt_rdbus | ib_ff;
      end
      if (instr_buffer_read_inverted_in) begin
         nxt_rdbus = nxt_rdbus | ~ib_ff;
      end
   end

   // --------------------
   // state registers
   // --------------------
   // data registers
   always_ff @(posedge clock_in or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         counter_ff <= WORD_RESET;
         lowp_ff    <= WORD_RESET;
         ib_ff      <= WORD_RESET;
         buf_ff     <= WORD_RESET;
         rdbus_ff   <= WORD_RESET;
      end else begin
         counter_ff <= nxt_counter;
         lowp_ff    <= nxt_lowp;
         ib_ff      <= nxt_ib;
         buf_ff     <= nxt_buf;
         rdbus_ff   <= nxt_rdbus;
      end
   end

   // address and order code with separately held complements,
   // so both rails come straight from flip-flops
   always_ff @(posedge clock_in or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         addr_ff    <= ADDR_RESET;
         addr_n_ff  <= ~ADDR_RESET;
         order_ff   <= ORDER_RESET;
         order_n_ff <= ~ORDER_RESET;
      end else begin
         addr_ff    <= nxt_addr;
         addr_n_ff  <= ~nxt_addr;
         order_ff   <= nxt_order;
         order_n_ff <= ~nxt_order;
      end
   end

   // interrupt program state; restart and start requests end it
   always_ff @(posedge clock_in or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         rupt_act_ff <= 1'b0;
         inhibit_ff  <= 1'b0;
      end else begin
         if (restart_eff | gts_eff | interrupt_return_in) begin
            rupt_act_ff <= 1'b0;
         end else if (rupt_take) begin
            rupt_act_ff <= 1'b1;
         end
         // zero outside interrupts unless the monitor holds it
         inhibit_ff <= (rupt_act_ff | rupt_take | monitor_interrupt_inhibit_in)
                       & ~restart_eff & ~gts_eff;
      end
   end

   // marks that the forced 0000 is the special transfer, not restart
   always_ff @(posedge clock_in or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         stc_ff <= 1'b0;
      end else if (newi_t12) begin
         stc_ff <= gts_eff;
      end
   end

   // --------------------
   // outputs
   // --------------------
   assign write_line_drive_out         = rdbus_ff;
   assign counter_out                  = counter_ff;
   assign low_product_register_out     = lowp_ff;
   assign instr_buffer_out             = ib_ff;
   assign address_reg_output_bit_out   = addr_ff;
   assign address_reg_output_bit_n_out = addr_n_ff;
   assign order_code_register_out      = order_ff;
   assign order_code_register_n_out    = order_n_ff;
   assign buffer_to_memory_line_out    = buf_ff;
   assign interrupt_active_out         = rupt_act_ff;
   assign interrupt_inhibit_out        = inhibit_ff;
   assign special_transfer_control_out = stc_ff;

endmodule : cprs_reg_set
